/* File: cksyn_pkg.sv */
// Package: register indices, field layout, reset values and types of the clock configuration block
package cksyn_pkg;

   // Register indices; byte address on the bus is four times the index
   localparam logic [5:0] IDX_TEST_CTRL = 6'h09;
   localparam logic [5:0] IDX_PLL3_SPREAD_HIGH = 6'h14;
   localparam logic [5:0] IDX_DIVIDER_ENABLES = 6'h15;
   localparam logic [5:0] IDX_CPU_PLL_DIVIDER_HIGH = 6'h16;
   localparam logic [5:0] IDX_CPU_PLL_DIVIDER_LOW = 6'h17;
   localparam logic [5:0] IDX_RESERVED_FIRST = 6'h18;
   localparam logic [5:0] IDX_RESERVED_LAST = 6'h3E;
   localparam logic [5:0] IDX_SPECIAL_POWER_FEATURES = 6'h3F;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int WORD_LSB = 2;

   // Field positions
   localparam int SPREAD_W = 7;
   localparam int DIVEN_CPU_BIT = 1;
   localparam int DIVEN_SRC_BIT = 0;
   localparam int CPUDIV_VCO8_BIT = 7;
   localparam int CPUDIV_VCO9_BIT = 6;
   localparam int REF_DIV_W = 6;
   localparam int VCO_DIV_W = 10;
   localparam int SPF_XTAL_BIT = 0;
   localparam int SPF_SATA_BIT = 1;
   localparam int TEST_ENTRY_POS = 3;
   localparam int TEST_CHOICE_POS = 4;

   // Reset values
   localparam logic [SPREAD_W-1:0] RST_SPREAD = 7'h00;
   localparam logic RST_CPU_MN_EN = 1'b0;
   localparam logic RST_SRC_MN_EN = 1'b0;
   localparam logic RST_XTAL_ON = 1'b1;
   localparam logic RST_SATA_ON = 1'b0;
   localparam logic RST_TEST_ENTRY = 1'b0;
   localparam logic RST_TEST_CHOICE = 1'b0;
   localparam logic [REF_DIV_W-1:0] RST_REF_DIV = 6'h00;
   localparam logic [VCO_DIV_W-1:0] RST_VCO_DIV = 10'h000;

   // Cycles after reset release before the strap is caught (two synchroniser stages plus one)
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Synchronised pin inputs
   localparam int PIN_W = 3;

   typedef enum logic [1:0] {
      CKSYN_OUT_NORMAL,
      CKSYN_OUT_HIZ,
      CKSYN_OUT_REFDIV
   } cksyn_out_mode_t;

   typedef enum logic [1:0] {
      CKSYN_TS_STRAP_WAIT,
      CKSYN_TS_NORMAL,
      CKSYN_TS_TEST_STRAP,
      CKSYN_TS_TEST_SOFT
   } cksyn_test_state_t;

   typedef struct packed {
      logic [SPREAD_W-1:0] spread_percent_bits;
      logic cpu_mn_en;
      logic src_mn_en;
      logic [REF_DIV_W-1:0] ref_div;
      logic [VCO_DIV_W-1:0] vco_div;
      logic crystal_powerdown_control;
      logic serial_ata_pll_power_feature;
      logic test_entry_bit;
      logic test_output_choice_bit;
   } cksyn_cfg_t;

   typedef struct packed {
      logic freq_select_c_above;
      logic freq_select_c;
      logic freq_select_b;
   } cksyn_pins_t;

   typedef struct packed {
      logic cpu_use_programmed;
      logic src_use_programmed;
      logic [REF_DIV_W-1:0] cpu_m;
      logic [VCO_DIV_W-1:0] cpu_n;
      logic [SPREAD_W-1:0] pll3_spread_high;
   } cksyn_pll_t;

endpackage

/* File: cksyn_sync2.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module cksyn_sync2
   import cksyn_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } cksyn_sync_state_t;

   cksyn_sync_state_t st;
   cksyn_sync_state_t next_st;

   generate
      if (WIDTH < 1)
      begin : g_bad_width
         $error("cksyn_sync2 needs WIDTH of at least 1");
      end
   endgenerate

   always_comb
   begin
      next_st = st;
      if (ce)
      begin
         next_st.meta = async_in;
         next_st.stable = st.meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st <= '0;
      else
         st <= next_st;
   end

   assign sync_out = st.stable;

endmodule

/* File: cksyn_config.sv */
// Configuration registers and test-mode control of the clock synthesizer, APB slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module cksyn_config
   import cksyn_pkg::*;
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic freq_select_c_above_threshold,
   input wire logic freq_select_c,
   input wire logic freq_select_b,
   // Frequency-select table settings
   input wire logic [REF_DIV_W-1:0] table_cpu_m,
   input wire logic [VCO_DIV_W-1:0] table_cpu_n,
   // Clock generator controls
   output cksyn_pll_t pll_ctrl,
   output cksyn_out_mode_t out_mode,
   output logic test_mode_active,
   output logic freq_select_c_latched,
   output logic crystal_on_in_powerdown,
   output logic serial_ata_pll_power_feature_power_on
);

   typedef struct packed {
      cksyn_cfg_t cfg;
      cksyn_test_state_t tstate;
      logic [1:0] settle;
      logic fs_c_latched;
      cksyn_out_mode_t out_mode;
      cksyn_pll_t pll;
      logic [DATA_W-1:0] rdata;
      logic slverr;
   } cksyn_state_t;

   cksyn_state_t st;
   cksyn_state_t next_st;
   cksyn_pins_t pins_raw;
   cksyn_pins_t pins;

   // Elaboration checks on the package layout this logic is written for
   generate
      if (ADDR_W - WORD_LSB != 6)
      begin : g_bad_addr
         $error("cksyn_config needs exactly six index bits in paddr");
      end
      if (DATA_W < 8)
      begin : g_bad_data
         $error("cksyn_config needs DATA_W of at least 8");
      end
      if (SPREAD_W != 7)
      begin : g_bad_spread
         $error("cksyn_config needs SPREAD_W of 7");
      end
      if (REF_DIV_W != 6)
      begin : g_bad_ref
         $error("cksyn_config needs REF_DIV_W of 6");
      end
      if (VCO_DIV_W != 10)
      begin : g_bad_vco
         $error("cksyn_config needs VCO_DIV_W of 10");
      end
      if (CPUDIV_VCO8_BIT > 7 || CPUDIV_VCO9_BIT > 7 || CPUDIV_VCO8_BIT == CPUDIV_VCO9_BIT)
      begin : g_bad_vco_pos
         $error("cksyn_config needs two distinct VCO high bit positions in a byte");
      end
      if (CPUDIV_VCO8_BIT < REF_DIV_W || CPUDIV_VCO9_BIT < REF_DIV_W)
      begin : g_bad_vco_overlap
         $error("cksyn_config VCO high bits overlap the reference divider field");
      end
      if (DIVEN_CPU_BIT > 7 || DIVEN_SRC_BIT > 7 || DIVEN_CPU_BIT == DIVEN_SRC_BIT)
      begin : g_bad_diven
         $error("cksyn_config needs two distinct divider-enable bits in a byte");
      end
      if (SPF_XTAL_BIT > 7 || SPF_SATA_BIT > 7 || SPF_XTAL_BIT == SPF_SATA_BIT)
      begin : g_bad_power
         $error("cksyn_config needs two distinct power bits in a byte");
      end
      if (TEST_ENTRY_POS > 7 || TEST_CHOICE_POS > 7 || TEST_ENTRY_POS == TEST_CHOICE_POS)
      begin : g_bad_test
         $error("cksyn_config needs two distinct test control bits in a byte");
      end
      if (PIN_W != $bits(cksyn_pins_t))
      begin : g_bad_pins
         $error("cksyn_config needs PIN_W equal to the pin struct width");
      end
      if (IDX_RESERVED_FIRST > IDX_RESERVED_LAST)
      begin : g_bad_reserved
         $error("cksyn_config needs a reserved range in ascending order");
      end
   endgenerate

   // Index of a word address
   function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
      word_index = addr[ADDR_W-1:WORD_LSB];
   endfunction

   // Register present at this index; reserved bytes count as present
   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx == IDX_TEST_CTRL) || (idx == IDX_PLL3_SPREAD_HIGH) ||
         (idx == IDX_DIVIDER_ENABLES) || (idx == IDX_CPU_PLL_DIVIDER_HIGH) ||
         (idx == IDX_CPU_PLL_DIVIDER_LOW) || (idx == IDX_SPECIAL_POWER_FEATURES) ||
         ((idx >= IDX_RESERVED_FIRST) && (idx <= IDX_RESERVED_LAST));
   endfunction

   // Read value of one register byte
   function automatic logic [7:0] read_byte(input logic [5:0] idx, input cksyn_cfg_t c);
      read_byte = 8'h00;
      case (idx)
         IDX_TEST_CTRL:
         begin
            read_byte[TEST_ENTRY_POS] = c.test_entry_bit;
            read_byte[TEST_CHOICE_POS] = c.test_output_choice_bit;
         end
         IDX_PLL3_SPREAD_HIGH:
            read_byte[SPREAD_W-1:0] = c.spread_percent_bits;
         IDX_DIVIDER_ENABLES:
         begin
            read_byte[DIVEN_CPU_BIT] = c.cpu_mn_en;
            read_byte[DIVEN_SRC_BIT] = c.src_mn_en;
         end
         IDX_CPU_PLL_DIVIDER_HIGH:
         begin
            read_byte[REF_DIV_W-1:0] = c.ref_div;
            read_byte[CPUDIV_VCO8_BIT] = c.vco_div[8];
            read_byte[CPUDIV_VCO9_BIT] = c.vco_div[9];
         end
         IDX_CPU_PLL_DIVIDER_LOW:
            read_byte = c.vco_div[7:0];
         IDX_SPECIAL_POWER_FEATURES:
         begin
            read_byte[SPF_XTAL_BIT] = c.crystal_powerdown_control;
            read_byte[SPF_SATA_BIT] = c.serial_ata_pll_power_feature;
         end
         default:
            read_byte = 8'h00;
      endcase
   endfunction

   // Pin synchronisers
   assign pins_raw.freq_select_c_above = freq_select_c_above_threshold;
   assign pins_raw.freq_select_c = freq_select_c;
   assign pins_raw.freq_select_b = freq_select_b;

   cksyn_sync2 #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   // Next-state logic
   always_comb
   begin
      logic [5:0] idx;
      logic wr;
      logic [7:0] wb;
      idx = word_index(paddr);
      wr = 1'b0;
      wb = pwdata[7:0];
      next_st = st;
      if (ce)
      begin
         // Setup phase prepares read data and error answer
         if (psel && !penable)
         begin
            next_st.slverr = !is_mapped(idx);
            next_st.rdata = '0;
            if (!pwrite)
               next_st.rdata[7:0] = read_byte(idx, st.cfg);
         end
         wr = psel && penable && pwrite && pstrb[0] && is_mapped(idx);

         // Register writes
         if (wr)
         begin
            case (idx)
               IDX_TEST_CTRL:
               begin
                  next_st.cfg.test_entry_bit = wb[TEST_ENTRY_POS];
                  next_st.cfg.test_output_choice_bit = wb[TEST_CHOICE_POS];
               end
               IDX_PLL3_SPREAD_HIGH:
                  next_st.cfg.spread_percent_bits = wb[SPREAD_W-1:0];
               IDX_DIVIDER_ENABLES:
               begin
                  next_st.cfg.cpu_mn_en = wb[DIVEN_CPU_BIT];
                  next_st.cfg.src_mn_en = wb[DIVEN_SRC_BIT];
               end
               IDX_CPU_PLL_DIVIDER_HIGH:
               begin
                  next_st.cfg.ref_div = wb[REF_DIV_W-1:0];
                  next_st.cfg.vco_div[8] = wb[CPUDIV_VCO8_BIT];
                  next_st.cfg.vco_div[9] = wb[CPUDIV_VCO9_BIT];
               end
               IDX_CPU_PLL_DIVIDER_LOW:
                  next_st.cfg.vco_div[7:0] = wb;
               IDX_SPECIAL_POWER_FEATURES:
               begin
                  next_st.cfg.crystal_powerdown_control = wb[SPF_XTAL_BIT];
                  next_st.cfg.serial_ata_pll_power_feature = wb[SPF_SATA_BIT];
               end
               default:
                  next_st.cfg = st.cfg;
            endcase
         end

         // Test-mode controller
         case (st.tstate)
            CKSYN_TS_STRAP_WAIT:
            begin
               next_st.settle = st.settle + 2'h1;
               if (st.settle == STRAP_SETTLE)
               begin
                  next_st.settle = st.settle;
                  next_st.cfg.ref_div = table_cpu_m;
                  next_st.cfg.vco_div = table_cpu_n;
                  next_st.fs_c_latched = pins.freq_select_c;
                  if (pins.freq_select_c_above)
                     next_st.tstate = CKSYN_TS_TEST_STRAP;
                  else
                     next_st.tstate = CKSYN_TS_NORMAL;
               end
            end
            CKSYN_TS_NORMAL:
            begin
               if (st.cfg.test_entry_bit)
                  next_st.tstate = CKSYN_TS_TEST_SOFT;
            end
            CKSYN_TS_TEST_STRAP:
               next_st.tstate = CKSYN_TS_TEST_STRAP;
            CKSYN_TS_TEST_SOFT:
               next_st.tstate = CKSYN_TS_TEST_SOFT;
            default:
               next_st.tstate = CKSYN_TS_STRAP_WAIT;
         endcase

         // Output mode from the state just reached
         case (next_st.tstate)
            CKSYN_TS_TEST_STRAP:
            begin
               if (!pins.freq_select_b && !next_st.cfg.test_output_choice_bit)
                  next_st.out_mode = CKSYN_OUT_HIZ;
               else
                  next_st.out_mode = CKSYN_OUT_REFDIV;
            end
            CKSYN_TS_TEST_SOFT:
            begin
               if (next_st.cfg.test_output_choice_bit)
                  next_st.out_mode = CKSYN_OUT_REFDIV;
               else
                  next_st.out_mode = CKSYN_OUT_HIZ;
            end
            default:
               next_st.out_mode = CKSYN_OUT_NORMAL;
         endcase

         // Divider selection toward the PLLs
         next_st.pll.cpu_use_programmed = next_st.cfg.cpu_mn_en;
         next_st.pll.src_use_programmed = next_st.cfg.src_mn_en;
         if (next_st.cfg.cpu_mn_en)
         begin
            next_st.pll.cpu_m = next_st.cfg.ref_div;
            next_st.pll.cpu_n = next_st.cfg.vco_div;
         end
         else
         begin
            next_st.pll.cpu_m = table_cpu_m;
            next_st.pll.cpu_n = table_cpu_n;
         end
         next_st.pll.pll3_spread_high = next_st.cfg.spread_percent_bits;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st.cfg.spread_percent_bits <= RST_SPREAD;
         st.cfg.cpu_mn_en <= RST_CPU_MN_EN;
         st.cfg.src_mn_en <= RST_SRC_MN_EN;
         st.cfg.ref_div <= RST_REF_DIV;
         st.cfg.vco_div <= RST_VCO_DIV;
         st.cfg.crystal_powerdown_control <= RST_XTAL_ON;
         st.cfg.serial_ata_pll_power_feature <= RST_SATA_ON;
         st.cfg.test_entry_bit <= RST_TEST_ENTRY;
         st.cfg.test_output_choice_bit <= RST_TEST_CHOICE;
         st.tstate <= CKSYN_TS_STRAP_WAIT;
         st.settle <= 2'h0;
         st.fs_c_latched <= 1'b0;
         st.out_mode <= CKSYN_OUT_NORMAL;
         st.pll <= '0;
         st.rdata <= '0;
         st.slverr <= 1'b0;
      end
      else
         st <= next_st;
   end

   // Outputs
   assign pready = psel && penable && ce;
   assign prdata = st.rdata;
   assign pslverr = pready && st.slverr;
   assign pll_ctrl = st.pll;
   assign out_mode = st.out_mode;
   assign test_mode_active = (st.tstate == CKSYN_TS_TEST_STRAP) ||
      (st.tstate == CKSYN_TS_TEST_SOFT);
   assign freq_select_c_latched = st.fs_c_latched;
   assign crystal_on_in_powerdown = st.cfg.crystal_powerdown_control;
   assign serial_ata_pll_power_feature_power_on = st.cfg.serial_ata_pll_power_feature;

endmodule

/* File: cksyn_config_checker.sv */
// Assertion checker of the clock configuration block
`timescale 1ns/1ps
module cksyn_config_checker
   import cksyn_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   // Controls
   input wire logic [REF_DIV_W-1:0] table_cpu_m,
   input wire cksyn_pll_t pll_ctrl,
   input wire cksyn_out_mode_t out_mode,
   input wire logic test_mode_active,
   input wire logic crystal_on_in_powerdown,
   input wire logic serial_ata_pll_power_feature_power_on
);
   logic [5:0] idx;
   logic wr_ok;
   assign idx = paddr[7:2];
   assign wr_ok = psel && penable && pwrite && ce && pstrb[0];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_spread_store: assert property (
      wr_ok && idx == IDX_PLL3_SPREAD_HIGH |=> pll_ctrl.pll3_spread_high == $past(pwdata[6:0]))
      else $error("spread bits not stored");
   a_cpu_enable: assert property (
      wr_ok && idx == IDX_DIVIDER_ENABLES |=> pll_ctrl.cpu_use_programmed == $past(pwdata[1]))
      else $error("cpu enable wrong");
   a_src_enable: assert property (
      wr_ok && idx == IDX_DIVIDER_ENABLES |=> pll_ctrl.src_use_programmed == $past(pwdata[0]))
      else $error("src enable wrong");
   a_ref_div: assert property (
      wr_ok && idx == IDX_CPU_PLL_DIVIDER_HIGH && pll_ctrl.cpu_use_programmed
      |=> pll_ctrl.cpu_m == $past(pwdata[5:0])
      && pll_ctrl.cpu_n[9:8] == {$past(pwdata[6]), $past(pwdata[7])})
      else $error("high divider byte mapped wrong");
   a_vco_low: assert property (
      wr_ok && idx == IDX_CPU_PLL_DIVIDER_LOW && pll_ctrl.cpu_use_programmed
      |=> pll_ctrl.cpu_n[7:0] == $past(pwdata[7:0]))
      else $error("low divider byte mapped wrong");
   a_table_use: assert property (
      !pll_ctrl.cpu_use_programmed && !$past(pll_ctrl.cpu_use_programmed) && $past(presetn)
      && $past(ce) && $stable(table_cpu_m) |-> pll_ctrl.cpu_m == table_cpu_m)
      else $error("table divider not used");
   a_reserved_ok: assert property (
      pslverr == (pready && !(idx == IDX_TEST_CTRL || idx >= IDX_PLL3_SPREAD_HIGH)))
      else $error("error response wrong");
   a_power_bits: assert property (
      wr_ok && idx == IDX_SPECIAL_POWER_FEATURES |=> crystal_on_in_powerdown == $past(pwdata[0])
      && serial_ata_pll_power_feature_power_on == $past(pwdata[1]))
      else $error("power bits not stored");
   a_soft_entry: assert property (
      wr_ok && idx == IDX_TEST_CTRL && pwdata[3] && !test_mode_active |-> ##[2:6] test_mode_active)
      else $error("test entry failed");
   a_test_hold: assert property (
      test_mode_active |=> test_mode_active)
      else $error("test mode left");
   a_normal_out: assert property (
      !test_mode_active && !$past(test_mode_active) |-> out_mode == CKSYN_OUT_NORMAL)
      else $error("output not normal");
   c_test_write: cover property (wr_ok && idx == IDX_TEST_CTRL);
   c_refdiv: cover property (out_mode == CKSYN_OUT_REFDIV);
   c_error: cover property (pslverr);
endmodule

/* File: cksyn_config_bench.sv */
// Testbench of the clock configuration block
`timescale 1ns/1ps
module cksyn_config_bench;
   import cksyn_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = 32'h00000000, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, er, fs_hi = 1'b0, fsc = 1'b0, fsb = 1'b0;
   logic [REF_DIV_W-1:0] tm = 6'h00;
   logic [VCO_DIV_W-1:0] tn = 10'h000;
   cksyn_pll_t pll;
   cksyn_out_mode_t om;
   logic tma, fscl, xon, sata;
   int fails = 0, checked = 0, seed = 40160;
   int mdl [64];
   int regs [$] = '{20, 21, 22, 23, 63, 40, 3};
   logic [7:0] sw [4] = '{8'h08, 8'h18, 8'h10, 8'h00};
   always #25 pclk = ~pclk;
   cksyn_config u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .freq_select_c_above_threshold(fs_hi), .freq_select_c(fsc), .freq_select_b(fsb),
      .table_cpu_m(tm), .table_cpu_n(tn), .pll_ctrl(pll), .out_mode(om),
      .test_mode_active(tma), .freq_select_c_latched(fscl),
      .crystal_on_in_powerdown(xon), .serial_ata_pll_power_feature_power_on(sata));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   function automatic int msk(input int ix);
      case (ix)
         9: return 32'h00000018;
         20: return 32'h0000007F;
         21, 63: return 32'h00000003;
         22, 23: return 32'h000000FF;
         default: return 32'h00000000;
      endcase
   endfunction
   task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'($random(seed)), d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      chk("pready", pready, 1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic acc(input logic w, input int ix, input logic [7:0] d);
      logic ok;
      ok = ix == 9 || ix >= 20;
      apb(w, 6'(ix), d);
      chk("pslverr", er, !ok);
      if (w && ok && pstrb[0])
         mdl[ix] = d & msk(ix);
      else if (!w)
         chk("prdata", rd, mdl[ix]);
   endtask
   task automatic chk_pll;
      logic [31:0] m, n;
      m = mdl[21][1] ? mdl[22] & 32'h0000003F : tm;
      n = mdl[21][1] ? {mdl[22][6], mdl[22][7], mdl[23][7:0]} : tn;
      #1;
      chk("cpu_m", pll.cpu_m, m);
      chk("cpu_n", pll.cpu_n, n);
      chk("spread", pll.pll3_spread_high, mdl[20]);
      chk("cpu_en", pll.cpu_use_programmed, mdl[21][1]);
      chk("src_en", pll.src_use_programmed, mdl[21][0]);
      chk("xtal", xon, mdl[63][0]);
      chk("sata", sata, mdl[63][1]);
   endtask
   task automatic rst(input logic hi);
      @(posedge pclk);
      presetn <= 1'b0;
      fs_hi <= hi;
      fsc <= 1'($random(seed));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      foreach (mdl[i]) mdl[i] = 0;
      mdl[63] = 1;
      mdl[22] = {tn[8], tn[9], tm};
      mdl[23] = tn[7:0];
      #1;
      chk("latched", fscl, fsc);
      chk("test", tma, hi);
   endtask
   initial
   begin
      #1000000;
      fails++;
      close_out();
   end
   initial
   begin
      tm <= 6'($random(seed));
      tn <= 10'($random(seed));
      rst(1'b0);
      chk("mode", om, CKSYN_OUT_NORMAL);
      for (int i = 0; i < 64; i++) acc(1'b0, i, 8'h00);
      repeat (4)
      begin
         foreach (regs[j])
         begin
            acc(1'b1, regs[j], 8'($random(seed)));
            acc(1'b0, regs[j], 8'h00);
         end
         chk_pll();
      end
      acc(1'b1, 21, 8'h02);
      chk_pll();
      acc(1'b1, 21, 8'h01);
      tm <= 6'($random(seed));
      repeat (2) @(posedge pclk);
      chk_pll();
      @(posedge pclk);
      pstrb <= 4'hE;
      acc(1'b1, 20, 8'h55);
      pstrb <= 4'hF;
      acc(1'b0, 20, 8'h00);
      foreach (sw[k])
      begin
         acc(1'b1, 9, sw[k]);
         fsb <= sw[k][3];
         repeat (4) @(posedge pclk);
         #1;
         chk("test", tma, 1);
         chk("mode", om, sw[k][4] ? CKSYN_OUT_REFDIV : CKSYN_OUT_HIZ);
      end
      rst(1'b1);
      for (int b = 0; b < 4; b++)
      begin
         acc(1'b1, 9, {3'h0, b[1], 4'h0});
         fsb <= b[0];
         repeat (4) @(posedge pclk);
         #1;
         chk("mode", om, b == 0 ? CKSYN_OUT_HIZ : CKSYN_OUT_REFDIV);
      end
      acc(1'b1, 9, 8'h00);
      ce <= 1'b0;
      fsb <= 1'b0;
      repeat (4) @(posedge pclk);
      #1;
      chk("frozen", om, CKSYN_OUT_REFDIV);
      @(posedge pclk);
      ce <= 1'b1;
      repeat (4) @(posedge pclk);
      #1;
      chk("mode", om, CKSYN_OUT_HIZ);
      close_out();
   end
endmodule
bind cksyn_config cksyn_config_checker u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .table_cpu_m(table_cpu_m),
   .pll_ctrl(pll_ctrl), .out_mode(out_mode), .test_mode_active(test_mode_active),
   .crystal_on_in_powerdown(crystal_on_in_powerdown), .serial_ata_pll_power_feature_power_on(serial_ata_pll_power_feature_power_on));
